// ===== sim/stmc_assertions.sv
module stmc_chk (
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        wb_cyc_in,
    input wire logic        wb_stb_in,
    input wire logic        wb_ack_out,
    input wire logic [31:0] wb_dat_out,
    input wire logic        irq_out,
    input wire logic        pixel_valid_in,
    input wire logic [15:0] divider_data_out,
    input wire logic        divider_valid_out,
    input wire logic        afe_bypass_out,
    input wire logic        adc_corr_bypass_out,
    input wire logic        afe_clk_falling_out,
    input wire logic        cds_in,
    input wire logic        second_lamp_output_normal_in,
    input wire logic        second_lamp_output_out,
    input wire logic        gpio6_out,
    input wire logic        gpio6_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////////////////////////////////////
    ack_once_a: assert property (wb_ack_out |=> !wb_ack_out)
        else $error("ack held past one cycle");
    ack_timely_a: assert property
        ((wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
        else $error("access not acked next cycle");
    read_upper_a: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h0)
        else $error("read data upper bits set");
    pix_valid_a: assert property (
        1'b1 |=> divider_valid_out == $past(pixel_valid_in))
        else $error("divider valid not one cycle after pixel");
    pix_hold_a: assert property (
        !divider_valid_out |-> $stable(divider_data_out))
        else $error("divider data moved without pixel");
    corr_needs_afe_a: assert property (
        adc_corr_bypass_out |-> afe_bypass_out)
        else $error("correction bypass without front end bypass");
    lamp_route_a: assert property (
        second_lamp_output_out == $past(cds_in) ||
        second_lamp_output_out == $past(second_lamp_output_normal_in))
        else $error("lamp output matches neither source");
    mode_quiet_a: assert property (
        $changed({afe_bypass_out, adc_corr_bypass_out, afe_clk_falling_out,
                  gpio6_out, gpio6_oe_out})
        |-> $past(wb_ack_out) || $past(wb_ack_out, 2))
        else $error("mode output changed without write");
    // irq is registered at the same edge as the ack of the clearing write
    irq_fall_a: assert property ($fell(irq_out) |-> wb_ack_out)
        else $error("irq dropped without bus write");
    pin_default_a: assert property (
        $fell(rst_in) |-> gpio6_oe_out && !gpio6_out)
        else $error("pin not driving low after reset");
endmodule : stmc_chk

// ===== sim/tb_top.sv
module tb_top
    import stmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in = 1'h0, rst_in = 1'h1;
    logic        wb_cyc_in = 1'h0, wb_stb_in = 1'h0, wb_we_in = 1'h0;
    logic [31:0] wb_adr_in = '0, wb_dat_in = '0, wb_dat_out;
    logic [3:0]  wb_sel_in = 4'h1;
    logic        wb_ack_out, irq_out, divider_valid_out, afe_bypass_out;
    logic        adc_corr_bypass_out, afe_clk_falling_out, gpio6_out;
    logic        second_lamp_output_out, gpio6_oe_out;
    logic [15:0] adc_data_in = '0, adc_raw_in = '0, divider_data_out;
    logic        pixel_valid_in = 1'h0, scan_start_in = 1'h0;
    logic        line_start_in = 1'h0, cds_in = 1'h0;
    logic        second_lamp_output_normal_in = 1'h0, gpio6_pin_in = 1'h0;
    logic [1:0]  amode = '0, src = '0;
    logic [15:0] stp = STMC_STEP_ONE, cnt = '0, forced = '0;
    logic [31:0] pq[$], rq[$];
    int          bad_count = 0, checks_done = 0;
    stmc_top stmc_top_inst (.*);
    always #2.5 clk_in = ~clk_in;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("checks %0d bad %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    // no cap on the wait: only the watchdog ends a hung access
    task automatic bus(input logic [6:0] idx, input logic we,
                       input logic [7:0] d);
        @(posedge clk_in);
        wb_cyc_in <= 1'h1;
        wb_stb_in <= 1'h1;
        wb_we_in  <= we;
        wb_adr_in <= {23'h0, idx, 2'h0};
        wb_dat_in <= {24'h0, d};
        do begin
            @(posedge clk_in);
        end while (wb_ack_out !== 1'h1);
        wb_cyc_in <= 1'h0;
        wb_stb_in <= 1'h0;
        wb_we_in  <= 1'h0;
    endtask : bus
    task automatic rd(input logic [6:0] idx, input logic [7:0] e);
        rq.push_back({24'h0, e});
        bus(idx, 1'h0, 8'h00);
    endtask : rd
    task automatic ctl(input logic [1:0] am, sr, st, input logic ed, cd);
        bus(STMC_IDX_CTRL, 1'h1, {cd, ed, st, sr, am});
        amode = am;
        src = sr;
        stp = st == 2'h1 ? STMC_STEP_FOUR : st == 2'h2 ? STMC_STEP_SIXTEEN
            : STMC_STEP_ONE;
    endtask : ctl
    // no lowering here so calls in a row give back-to-back pixels
    task automatic px(input logic ln, input logic sc);
        logic [15:0] a, r, e;
        a = 16'($urandom);
        r = 16'($urandom);
        if (src < 2'h2 || (src == 2'h2 && sc) || (src == 2'h3 && ln)) cnt = '0;
        if (src == 2'h0) e = amode == 2'h2 ? {8'h00, r[15:8]}
            : amode == 2'h3 ? {8'h00, r[7:0]} : a;
        else if (src == 2'h1) e = forced;
        else begin
            e = cnt;
            cnt += stp;
        end
        pq.push_back({16'h0, e});
        @(posedge clk_in);
        pixel_valid_in <= 1'h1;
        line_start_in  <= ln;
        scan_start_in  <= sc;
        adc_data_in    <= a;
        adc_raw_in     <= r;
    endtask : px
    task automatic idl(input int n);
        @(posedge clk_in);
        pixel_valid_in <= 1'h0;
        line_start_in  <= 1'h0;
        scan_start_in  <= 1'h0;
        repeat (n) @(posedge clk_in);
    endtask : idl
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk_in) begin
        if (divider_valid_out === 1'h1)
            check(divider_data_out, pq.pop_front());
        if (wb_ack_out === 1'h1 && wb_we_in === 1'h0)
            check(wb_dat_out, rq.pop_front());
    end
    initial begin
        #50us;
        bad_count++;
        summarize();
    end
    initial begin
        void'($urandom(15));
        repeat (5) @(posedge clk_in);
        rst_in <= 1'h0;
        check(gpio6_oe_out, 1'h1);
        check(gpio6_out, 1'h0);
        rd(STMC_IDX_GPIO_CFG, STMC_GPIO_CFG_RST);
        rd(STMC_IDX_CTRL, 8'h00);
        rd(STMC_IDX_FORCED_HI, 8'h00);
        bus(STMC_IDX_RSVD_LAST, 1'h1, 8'h00);
        rd(STMC_IDX_RSVD_FIRST, 8'h00);
        rd(7'h7F, 8'h00);
        $display("reset test done");
        bus(STMC_IDX_FORCED_HI, 1'h1, 8'hA5);
        bus(STMC_IDX_FORCED_LO, 1'h1, 8'h3C);
        // byte lane 0 off: write acked but ignored
        wb_sel_in <= 4'h0;
        bus(STMC_IDX_FORCED_HI, 1'h1, 8'h5A);
        wb_sel_in <= 4'h1;
        rd(STMC_IDX_FORCED_HI, 8'hA5);
        forced = 16'hA53C;
        ctl(2'h0, 2'h1, 2'h0, 1'h0, 1'h0);
        px(1'h0, 1'h0);
        px(1'h0, 1'h0);
        idl(2);
        bus(STMC_IDX_FORCED_LO, 1'h1, 8'hC3);
        forced[7:0] = 8'hC3;
        px(1'h0, 1'h0);
        idl(2);
        $display("forced code test done");
        for (int m = 0; m < 4; m++) begin
            ctl(m[1:0], 2'h0, 2'h0, 1'h0, 1'h0);
            idl(1);
            check(afe_bypass_out, m != 0);
            check(adc_corr_bypass_out, m > 1);
            px(1'h0, 1'h0);
            px(1'h0, 1'h0);
            idl(2);
        end
        $display("adc mode test done");
        // scan pulse in line mode must not clear
        for (int s = 0; s < 4; s++) begin
            ctl(2'h0, 2'h3, s[1:0], 1'h0, 1'h0);
            px(1'h1, 1'h0);
            px(1'h0, 1'h0);
            px(1'h0, 1'h1);
            px(1'h1, 1'h0);
            px(1'h0, 1'h0);
            idl(2);
        end
        ctl(2'h0, 2'h2, 2'h2, 1'h0, 1'h0);
        px(1'h0, 1'h1);
        px(1'h1, 1'h0);
        px(1'h0, 1'h1);
        px(1'h0, 1'h0);
        idl(2);
        $display("counter test done");
        // clock edge bit kept at zero, as software must
        ctl(2'h0, 2'h0, 2'h0, 1'h0, 1'h1);
        cds_in <= 1'h1;
        idl(2);
        check(second_lamp_output_out, 1'h1);
        check(afe_clk_falling_out, 1'h0);
        ctl(2'h0, 2'h0, 2'h0, 1'h0, 1'h0);
        cds_in           <= 1'h0;
        second_lamp_output_normal_in <= 1'h1;
        idl(2);
        check(second_lamp_output_out, 1'h1);
        check(afe_clk_falling_out, 1'h0);
        $display("lamp test done");
        bus(STMC_IDX_GPIO_CFG, 1'h1, 8'h90);
        idl(2);
        check(gpio6_out, 1'h1);
        bus(STMC_IDX_GPIO_CFG, 1'h1, 8'h20);
        gpio6_pin_in <= 1'h1;
        idl(6);
        check(gpio6_oe_out, 1'h0);
        rd(STMC_IDX_PIN_STATE, 8'h01);
        gpio6_pin_in <= 1'h0;
        idl(6);
        rd(STMC_IDX_PIN_STATE, 8'h00);
        bus(STMC_IDX_GPIO_CFG, 1'h1, 8'h00);
        idl(6);
        rd(STMC_IDX_PIN_STATE, 8'h01);
        bus(STMC_IDX_GPIO_CFG, 1'h1, 8'h60);
        bus(STMC_IDX_IRQ_CLR, 1'h1, 8'h07);
        bus(STMC_IDX_IRQ_EN, 1'h1, 8'h01);
        idl(2);
        check(irq_out, 1'h0);
        gpio6_pin_in <= 1'h1;
        idl(3);
        gpio6_pin_in <= 1'h0;
        idl(6);
        check(irq_out, 1'h1);
        rd(STMC_IDX_PIN_STATE, 8'h01);
        rd(STMC_IDX_PIN_STATE, 8'h00);
        rd(STMC_IDX_IRQ_STS, 8'h01);
        bus(STMC_IDX_IRQ_EN, 1'h1, 8'h00);
        idl(2);
        check(irq_out, 1'h0);
        bus(STMC_IDX_IRQ_EN, 1'h1, 8'h01);
        idl(2);
        check(irq_out, 1'h1);
        bus(STMC_IDX_IRQ_CLR, 1'h1, 8'h01);
        idl(2);
        check(irq_out, 1'h0);
        rd(STMC_IDX_IRQ_STS, 8'h00);
        $display("pin and irq test done");
        summarize();
    end
endmodule : tb_top
bind stmc_top stmc_chk stmc_chk_inst (.*);

// ===== verilog/stmc_pkg.sv
package stmc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus geometry: register index = byte address / 4
    localparam int          STMC_IDX_W          = 7;
    localparam int          STMC_IDX_LSB        = 2;
    localparam int          STMC_DATA_W         = 16;

    ////////////////////////////////////////////////////////////////////////
    // register indices
    localparam logic [6:0]  STMC_IDX_GPIO_CFG   = 7'h5B;
    localparam logic [6:0]  STMC_IDX_FORCED_HI  = 7'h5C;
    localparam logic [6:0]  STMC_IDX_FORCED_LO  = 7'h5D;
    localparam logic [6:0]  STMC_IDX_CTRL       = 7'h5E;
    localparam logic [6:0]  STMC_IDX_RSVD_FIRST = 7'h5F;
    localparam logic [6:0]  STMC_IDX_RSVD_LAST  = 7'h68;
    localparam logic [6:0]  STMC_IDX_PIN_STATE  = 7'h70;
    localparam logic [6:0]  STMC_IDX_IRQ_STS    = 7'h71;
    localparam logic [6:0]  STMC_IDX_IRQ_CLR    = 7'h72;
    localparam logic [6:0]  STMC_IDX_IRQ_EN     = 7'h73;

    ////////////////////////////////////////////////////////////////////////
    // test mode control fields
    localparam int          STMC_ADC_LSB        = 0;
    localparam int          STMC_SRC_LSB        = 2;
    localparam int          STMC_STEP_LSB       = 4;
    localparam int          STMC_EDGE_BIT       = 6;
    localparam int          STMC_CDS_BIT        = 7;

    // general i/o six configuration fields
    localparam int          STMC_DIR_BIT        = 4;
    localparam int          STMC_POL_BIT        = 5;
    localparam int          STMC_LVL_EDGE_BIT   = 6;
    localparam int          STMC_OUT_BIT        = 7;
    localparam int          STMC_STATE_BIT      = 0;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  STMC_CTRL_RST       = 8'h00;
    localparam logic [7:0]  STMC_FORCED_RST     = 8'h00;
    // output, driving low
    localparam logic [7:0]  STMC_GPIO_CFG_RST   = 8'h10;

    ////////////////////////////////////////////////////////////////////////
    // interrupt status layout
    localparam int          STMC_IRQ_W          = 3;
    localparam int          STMC_IRQ_PIN        = 0;
    localparam int          STMC_IRQ_SCAN       = 1;
    localparam int          STMC_IRQ_LINE       = 2;

    ////////////////////////////////////////////////////////////////////////
    // counter steps
    localparam logic [15:0] STMC_STEP_ONE       = 16'h0001;
    localparam logic [15:0] STMC_STEP_FOUR      = 16'h0004;
    localparam logic [15:0] STMC_STEP_SIXTEEN   = 16'h0010;
    localparam logic [15:0] STMC_CNT_ZERO       = 16'h0000;
    localparam logic [7:0]  STMC_BYTE_ZERO      = 8'h00;

    typedef enum logic [1:0] {
        STMC_ADC_NORMAL,
        STMC_ADC_AFE_BYP,
        STMC_ADC_RAW_HI,
        STMC_ADC_RAW_LO
    } stmc_adc_mode_t;

    typedef enum logic [1:0] {
        STMC_SRC_ADC,
        STMC_SRC_FORCED,
        STMC_SRC_CNT_SCAN,
        STMC_SRC_CNT_LINE
    } stmc_pix_src_t;

    typedef enum logic [1:0] {
        STMC_STEP_1,
        STMC_STEP_4,
        STMC_STEP_16,
        STMC_STEP_NA
    } stmc_step_t;

endpackage : stmc_pkg

// ===== verilog/stmc_top.sv
// What this block does
// - level mode: input six state bit follows the pin's true level.
// - edge mode: state bit set if pin was true since last status read.
// - as output, input six pin drives low for bit 0, high for 1.
// - after reset, input six is an output driving low.
// - sixteen-bit forced code in two byte registers feeds the divider.
// - two-bit adc test field picks normal, bypass, raw high, raw low.
// - input select picks adc, forced code, per-scan or per-line counter.
// - per-scan counter mode clears the counter at each scan start.
// - per-line counter mode clears the counter at each line start.
// - counter starts at zero and advances once per data pixel.
// - increment select gives step 1, 4 or 16; fourth code unused.
// - observe bit routes sampling signal onto second lamp output.
module stmc_top
    import stmc_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [31:0] wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    output logic             irq_out,
    input  wire logic [15:0] adc_data_in,
    input  wire logic [15:0] adc_raw_in,
    input  wire logic        pixel_valid_in,
    input  wire logic        scan_start_in,
    input  wire logic        line_start_in,
    output logic      [15:0] divider_data_out,
    output logic             divider_valid_out,
    output logic             afe_bypass_out,
    output logic             adc_corr_bypass_out,
    output logic             afe_clk_falling_out,
    input  wire logic        cds_in,
    input  wire logic        second_lamp_output_normal_in,
    output logic             second_lamp_output_out,
    input  wire logic        gpio6_pin_in,
    output logic             gpio6_out,
    output logic             gpio6_oe_out
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic                  sync1;
        logic                  sync2;
        logic                  prev_true;
        logic                  edge_latch;
        logic [7:0]            gpio_cfg;
        logic [7:0]            forced_hi;
        logic [7:0]            forced_lo;
        logic [7:0]            ctrl;
        logic [15:0]           cnt;
        logic [STMC_IRQ_W-1:0] irq_sts;
        logic [STMC_IRQ_W-1:0] irq_en;
        logic                  irq;
        logic                  ack;
        logic [31:0]           dat;
        logic [15:0]           div_data;
        logic                  div_valid;
        logic                  afe_byp;
        logic                  corr_byp;
        logic                  clk_fall;
        logic                  second_lamp_output;
        logic                  gpio_out;
        logic                  gpio_oe;
    } stmc_state_t;

    localparam stmc_state_t STMC_STATE_RST = '{
        sync1:      1'b0,
        sync2:      1'b0,
        prev_true:  1'b0,
        edge_latch: 1'b0,
        gpio_cfg:   STMC_GPIO_CFG_RST,
        forced_hi:  STMC_FORCED_RST,
        forced_lo:  STMC_FORCED_RST,
        ctrl:       STMC_CTRL_RST,
        cnt:        STMC_CNT_ZERO,
        irq_sts:    '0,
        irq_en:     '0,
        irq:        1'b0,
        ack:        1'b0,
        dat:        '0,
        div_data:   STMC_CNT_ZERO,
        div_valid:  1'b0,
        afe_byp:    1'b0,
        corr_byp:   1'b0,
        clk_fall:   1'b0,
        second_lamp_output:     1'b0,
        gpio_out:   STMC_GPIO_CFG_RST[STMC_OUT_BIT],
        gpio_oe:    STMC_GPIO_CFG_RST[STMC_DIR_BIT]
    };

    stmc_state_t s_reg;
    stmc_state_t s_next;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic                  access;
        logic                  wr;
        logic                  rd;
        logic [STMC_IDX_W-1:0] idx;
        logic                  is_input;
        logic                  pin_true;
        logic                  state_bit;
        logic                  state_rd;
        logic [STMC_IRQ_W-1:0] ev;
        logic [STMC_IRQ_W-1:0] clr;
        logic                  cnt_clear;
        logic [15:0]           cnt_base;
        logic [15:0]           step;
        logic [15:0]           adc_word;
        logic [15:0]           src_word;
        stmc_adc_mode_t        adc_mode;
        stmc_pix_src_t         src;
        stmc_step_t            step_sel;

        s_next    = s_reg;
        access    = 1'b0;
        wr        = 1'b0;
        rd        = 1'b0;
        idx       = '0;
        is_input  = 1'b0;
        pin_true  = 1'b0;
        state_bit = 1'b0;
        state_rd  = 1'b0;
        ev        = '0;
        clr       = '0;
        cnt_clear = 1'b0;
        cnt_base  = STMC_CNT_ZERO;
        step      = STMC_STEP_ONE;
        adc_word  = STMC_CNT_ZERO;
        src_word  = STMC_CNT_ZERO;
        adc_mode  = stmc_adc_mode_t'(s_reg.ctrl[STMC_ADC_LSB +: 2]);
        src       = stmc_pix_src_t'(s_reg.ctrl[STMC_SRC_LSB +: 2]);
        step_sel  = stmc_step_t'(s_reg.ctrl[STMC_STEP_LSB +: 2]);

        ////////////////////////////////////////////////////////////////////
        // wishbone slave: one access per ack, ack one cycle after strobe
        access = wb_cyc_in & wb_stb_in & ~s_reg.ack;
        wr     = access & wb_we_in & wb_sel_in[0];
        rd     = access & ~wb_we_in;
        idx    = wb_adr_in[STMC_IDX_LSB +: STMC_IDX_W];
        s_next.ack = access;

        ////////////////////////////////////////////////////////////////////
        // general i/o six
        // pin is asynchronous; only sync2 is looked at
        s_next.sync1 = gpio6_pin_in;
        s_next.sync2 = s_reg.sync1;
        is_input = ~s_reg.gpio_cfg[STMC_DIR_BIT];
        pin_true = is_input &
                   (s_reg.sync2 == s_reg.gpio_cfg[STMC_POL_BIT]);
        state_rd = rd && (idx == STMC_IDX_PIN_STATE);
        // set wins over the read that clears it
        s_next.edge_latch = (s_reg.edge_latch & ~state_rd) | pin_true;
        if (s_reg.gpio_cfg[STMC_LVL_EDGE_BIT]) begin
            state_bit = is_input & s_reg.edge_latch;
        end else begin
            state_bit = pin_true;
        end
        s_next.prev_true = pin_true;
        s_next.gpio_oe   = s_reg.gpio_cfg[STMC_DIR_BIT];
        s_next.gpio_out  = s_reg.gpio_cfg[STMC_OUT_BIT];

        ////////////////////////////////////////////////////////////////////
        // register writes; reserved range and unmapped indices ignore data
        if (wr) begin
            unique case (idx)
                STMC_IDX_GPIO_CFG: begin
                    s_next.gpio_cfg = wb_dat_in[7:0];
                end
                STMC_IDX_FORCED_HI: begin
                    s_next.forced_hi = wb_dat_in[7:0];
                end
                STMC_IDX_FORCED_LO: begin
                    s_next.forced_lo = wb_dat_in[7:0];
                end
                STMC_IDX_CTRL: begin
                    s_next.ctrl = wb_dat_in[7:0];
                end
                STMC_IDX_IRQ_CLR: begin
                    clr = wb_dat_in[STMC_IRQ_W-1:0];
                end
                STMC_IDX_IRQ_EN: begin
                    s_next.irq_en = wb_dat_in[STMC_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // register reads; data registered alongside ack
        if (rd) begin
            s_next.dat = '0;
            unique case (idx)
                STMC_IDX_GPIO_CFG: begin
                    s_next.dat[7:STMC_DIR_BIT] =
                        s_reg.gpio_cfg[7:STMC_DIR_BIT];
                end
                STMC_IDX_FORCED_HI: begin
                    s_next.dat[7:0] = s_reg.forced_hi;
                end
                STMC_IDX_FORCED_LO: begin
                    s_next.dat[7:0] = s_reg.forced_lo;
                end
                STMC_IDX_CTRL: begin
                    s_next.dat[7:0] = s_reg.ctrl;
                end
                STMC_IDX_PIN_STATE: begin
                    s_next.dat[STMC_STATE_BIT] = state_bit;
                end
                STMC_IDX_IRQ_STS: begin
                    s_next.dat[STMC_IRQ_W-1:0] = s_reg.irq_sts;
                end
                STMC_IDX_IRQ_EN: begin
                    s_next.dat[STMC_IRQ_W-1:0] = s_reg.irq_en;
                end
                default: begin
                end
            endcase
        end

        ////////////////////////////////////////////////////////////////////
        // front-end steering
        s_next.afe_byp  = (adc_mode != STMC_ADC_NORMAL);
        s_next.corr_byp = (adc_mode == STMC_ADC_RAW_HI) ||
                          (adc_mode == STMC_ADC_RAW_LO);
        // falling edge is never recommended; passed through untouched
        s_next.clk_fall = s_reg.ctrl[STMC_EDGE_BIT];
        s_next.second_lamp_output   = s_reg.ctrl[STMC_CDS_BIT] ?
                          cds_in : second_lamp_output_normal_in;

        unique case (adc_mode)
            STMC_ADC_NORMAL,
            STMC_ADC_AFE_BYP: begin
                adc_word = adc_data_in;
            end
            STMC_ADC_RAW_HI: begin
                adc_word = {STMC_BYTE_ZERO, adc_raw_in[15:8]};
            end
            STMC_ADC_RAW_LO: begin
                adc_word = {STMC_BYTE_ZERO, adc_raw_in[7:0]};
            end
        endcase

        ////////////////////////////////////////////////////////////////////
        // test counter
        unique case (step_sel)
            STMC_STEP_1: begin
                step = STMC_STEP_ONE;
            end
            STMC_STEP_4: begin
                step = STMC_STEP_FOUR;
            end
            STMC_STEP_16: begin
                step = STMC_STEP_SIXTEEN;
            end
            // unused code behaves as step one rather than freezing
            STMC_STEP_NA: begin
                step = STMC_STEP_ONE;
            end
        endcase

        cnt_clear = ((src == STMC_SRC_CNT_SCAN) && scan_start_in) ||
                    ((src == STMC_SRC_CNT_LINE) && line_start_in);
        cnt_base  = cnt_clear ? STMC_CNT_ZERO : s_reg.cnt;

        if ((src == STMC_SRC_CNT_SCAN) || (src == STMC_SRC_CNT_LINE)) begin
            if (pixel_valid_in) begin
                s_next.cnt = 16'(cnt_base + step);
            end else begin
                s_next.cnt = cnt_base;
            end
        end else begin
            // held at zero so a counter mode entered from adc or forced input starts from zero
            s_next.cnt = STMC_CNT_ZERO;
        end

        ////////////////////////////////////////////////////////////////////
        // divider input select
        unique case (src)
            STMC_SRC_ADC: begin
                src_word = adc_word;
            end
            STMC_SRC_FORCED: begin
                src_word = {s_reg.forced_hi, s_reg.forced_lo};
            end
            STMC_SRC_CNT_SCAN,
            STMC_SRC_CNT_LINE: begin
                src_word = cnt_base;
            end
        endcase

        s_next.div_valid = pixel_valid_in;
        if (pixel_valid_in) begin
            s_next.div_data = src_word;
        end

        ////////////////////////////////////////////////////////////////////
        // interrupts; a new event beats a clear in the same cycle
        ev[STMC_IRQ_PIN]  = pin_true & ~s_reg.prev_true;
        ev[STMC_IRQ_SCAN] = scan_start_in;
        ev[STMC_IRQ_LINE] = line_start_in;
        s_next.irq_sts = (s_reg.irq_sts & ~clr) | ev;
        s_next.irq     = |(s_next.irq_sts & s_next.irq_en);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_reg <= STMC_STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign wb_dat_out             = s_reg.dat;
    assign wb_ack_out             = s_reg.ack;
    assign irq_out                = s_reg.irq;
    assign divider_data_out       = s_reg.div_data;
    assign divider_valid_out      = s_reg.div_valid;
    assign afe_bypass_out         = s_reg.afe_byp;
    assign adc_corr_bypass_out    = s_reg.corr_byp;
    assign afe_clk_falling_out    = s_reg.clk_fall;
    assign second_lamp_output_out = s_reg.second_lamp_output;
    assign gpio6_out              = s_reg.gpio_out;
    assign gpio6_oe_out           = s_reg.gpio_oe;

endmodule : stmc_top
